/* shared/capture_compare_timer_regs.svh */
`ifndef CAPTURE_COMPARE_TIMER_REGS_SVH
`define CAPTURE_COMPARE_TIMER_REGS_SVH

// Counter and prescaler geometry
`define CCT_CNT_W        32
`define CCT_PRESC_W      12

// Conditioned pin positions
`define CCT_PIN_NUM      2
`define CCT_PIN_EXTCLK   0
`define CCT_PIN_CAPTURE  1

// Reset values
`define CCT_CNT_RST      32'h0000_0000
`define CCT_PRESC_RST    12'h000

`endif

/* shared/capture_compare_timer_pkg.sv */
`default_nettype none

package capture_compare_timer_pkg;

  typedef enum logic
  {
    MODE_FREE_RUN,
    MODE_PERIODIC
  } timer_mode_e;

  typedef enum logic
  {
    EDGE_LEADING,
    EDGE_TRAILING
  } capture_edge_e;

  typedef enum logic
  {
    CLK_SRC_INTERNAL,
    CLK_SRC_EXTERNAL
  } clk_src_e;

endpackage

`default_nettype wire

/* shared/pin_edge_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface pin_edge_if #(parameter int N = 2);
  logic [N-1:0] raw;
  logic [N-1:0] rise;
  logic [N-1:0] fall;

  modport cond (input raw, output rise, output fall);
  modport user (output raw, input rise, input fall);
endinterface

`default_nettype wire

/* hdl/pin_conditioner.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_conditioner #(
  parameter int N = 2
) (
  // Clock and reset
  input  wire logic    i_sys_clk,
  input  wire logic    i_arst_n,
  // Pins in, edge pulses out
  pin_edge_if.cond     pins
);

  typedef struct packed
  {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] lvl;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
  } cond_state_s;

  cond_state_s st_ff;
  cond_state_s nxt_st;
  logic [N-1:0] agree;

  if (N < 1)
  begin : g_bad_n
    $error("pin_conditioner needs at least one pin");
  end

  // Three-stage synchroniser; a change counts once stages two and three agree
  always_comb
  begin
    nxt_st = st_ff;
    agree = ~(st_ff.s2 ^ st_ff.s3);
    nxt_st.s1 = pins.raw;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.lvl = (agree & st_ff.s3) | (~agree & st_ff.lvl);
    nxt_st.rise = nxt_st.lvl & ~st_ff.lvl;
    nxt_st.fall = ~nxt_st.lvl & st_ff.lvl;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign pins.rise = st_ff.rise;
  assign pins.fall = st_ff.fall;

  a_rise_one_cycle : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    st_ff.rise[0] |=> !st_ff.rise[0])
    else $error("edge pulse held longer than one cycle");

endmodule // pin_conditioner

`default_nettype wire

/* hdl/general_capture_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_timer_regs.svh"

module general_capture_timer
  import capture_compare_timer_pkg::*;
#(
  parameter int CNT_W   = `CCT_CNT_W,
  parameter int PRESC_W = `CCT_PRESC_W
) (
  // Clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_arst_n,
  // Configuration
  input  wire logic               i_enable,
  input  wire timer_mode_e        i_mode,
  input  wire clk_src_e           i_clk_src,
  input  wire capture_edge_e      i_capture_edge,
  input  wire logic [PRESC_W-1:0] i_prescale,
  input  wire logic [CNT_W-1:0]   i_compare,
  // Flag clears
  input  wire logic               i_cmp_flag_clr,
  input  wire logic               i_cap_flag_clr,
  // External pins
  input  wire logic               i_ext_clk,
  input  wire logic               i_capture_pin,
  // Status
  output logic [CNT_W-1:0]        o_count,
  output logic [CNT_W-1:0]        o_capture,
  output logic                    o_cmp_flag,
  output logic                    o_cap_flag,
  output logic                    o_cmp_irq
);

  typedef struct packed
  {
    logic [CNT_W-1:0]   count;
    logic [CNT_W-1:0]   capture;
    logic [PRESC_W-1:0] presc_cnt;
    logic               cmp_flag;
    logic               cap_flag;
  } timer_state_s;

  timer_state_s st_ff;
  timer_state_s nxt_st;
  logic         tick;
  logic         adv;
  logic         cmp_hit;
  logic         cap_evt;

  if (CNT_W != 32)
  begin : g_bad_cnt
    $error("general_capture_timer counter must be 32 bits");
  end
  if (PRESC_W < 1 || PRESC_W > 16)
  begin : g_bad_presc
    $error("general_capture_timer prescaler width must be 1 to 16");
  end

  pin_edge_if #(.N(`CCT_PIN_NUM)) pins ();

  // One driver for the whole raw pin vector
  always_comb
  begin
    pins.raw                   = '0;
    pins.raw[`CCT_PIN_EXTCLK]  = i_ext_clk;
    pins.raw[`CCT_PIN_CAPTURE] = i_capture_pin;
  end

  pin_conditioner #(.N(`CCT_PIN_NUM)) u_pin_conditioner (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .pins      (pins.cond)
  );

  always_comb
  begin
    nxt_st = st_ff;
    // Count clock source
    tick = i_enable && ((i_clk_src == CLK_SRC_INTERNAL) || pins.rise[`CCT_PIN_EXTCLK]);
    // Prescaler divides by prescale + 1
    adv = tick && (st_ff.presc_cnt == i_prescale);
    if (!i_enable)
      nxt_st.presc_cnt = PRESC_W'(`CCT_PRESC_RST);
    else if (adv)
      nxt_st.presc_cnt = PRESC_W'(`CCT_PRESC_RST);
    else if (tick)
      nxt_st.presc_cnt = st_ff.presc_cnt + PRESC_W'(1);
    // Counter advance
    if (adv)
    begin
      if (i_mode == MODE_PERIODIC && st_ff.count == i_compare)
        nxt_st.count = CNT_W'(`CCT_CNT_RST);
      else
        nxt_st.count = st_ff.count + CNT_W'(1);
    end
    // Compare match as the counter arrives on the compare value
    cmp_hit = adv && (nxt_st.count == i_compare);
    if (cmp_hit)
      nxt_st.cmp_flag = 1'b1;
    else if (i_cmp_flag_clr)
      nxt_st.cmp_flag = 1'b0;
    // Capture on the chosen pin edge
    cap_evt = (i_capture_edge == EDGE_LEADING) ? pins.rise[`CCT_PIN_CAPTURE]
                                               : pins.fall[`CCT_PIN_CAPTURE];
    if (cap_evt)
    begin
      nxt_st.capture = st_ff.count;
      nxt_st.cap_flag = 1'b1;
    end
    else if (i_cap_flag_clr)
      nxt_st.cap_flag = 1'b0;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign o_count    = st_ff.count;
  assign o_capture  = st_ff.capture;
  assign o_cmp_flag = st_ff.cmp_flag;
  assign o_cap_flag = st_ff.cap_flag;
  assign o_cmp_irq  = st_ff.cmp_flag;

  // Checks
  a_counter_wrap : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    adv && i_mode == MODE_FREE_RUN && st_ff.count == 32'hffff_ffff |=> o_count == 32'h0000_0000)
    else $error("free-running counter did not wrap to zero");

  a_presc_divide : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    st_ff.presc_cnt != i_prescale |=> o_count == $past(o_count))
    else $error("counter advanced before prescaler terminal count");

  a_capture_latch : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    cap_evt |=> o_capture == $past(st_ff.count) && o_cap_flag)
    else $error("capture did not latch the counter");

  a_edge_select : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    pins.fall[`CCT_PIN_CAPTURE] && i_capture_edge == EDGE_LEADING
    |=> o_capture == $past(o_capture) && (!o_cap_flag || $past(o_cap_flag)))
    else $error("trailing edge captured in leading-edge mode");

  a_periodic_restart : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    adv && i_mode == MODE_PERIODIC && st_ff.count == i_compare |=> o_count == 32'h0000_0000)
    else $error("periodic mode did not restart at compare");

  a_cmp_irq : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    o_count != $past(o_count) && o_count == $past(i_compare) |-> o_cmp_flag && o_cmp_irq)
    else $error("compare match did not raise flag and interrupt");

  a_ext_clk_gate : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    i_clk_src == CLK_SRC_EXTERNAL && !pins.rise[`CCT_PIN_EXTCLK] |=> o_count == $past(st_ff.count))
    else $error("counter moved without an external clock edge");

  a_free_pass : assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    adv && i_mode == MODE_FREE_RUN && st_ff.count == i_compare && st_ff.count != 32'hffff_ffff
    |=> o_count == $past(st_ff.count) + 32'h1)
    else $error("free-running counter stopped at compare");

  c_periodic_match : cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    adv && i_mode == MODE_PERIODIC && st_ff.count == i_compare);
  c_capture_trail : cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    cap_evt && i_capture_edge == EDGE_TRAILING);
  c_ext_advance : cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    adv && i_clk_src == CLK_SRC_EXTERNAL);

endmodule // general_capture_timer

`default_nettype wire

/* tb/capture_event_source.sv */
`timescale 1ns/1ps
`default_nettype none

module capture_event_source (
  // Clock
  input  wire logic       i_sys_clk,
  // Commands from the bench
  input  wire logic       i_clk_run,
  input  wire logic       i_pulse_go,
  input  wire logic [7:0] i_pulse_len,
  // Pins toward the timer
  output logic            o_ext_clk,
  output logic            o_capture_pin
);
  logic [2:0] phase_ff = 3'h0;
  logic [7:0] pulse_ff = 8'h00;

  // Clock stands low outside runs; three cycles high, three low
  always_ff @(posedge i_sys_clk)
  begin
    phase_ff <= (!i_clk_run || phase_ff == 3'h5) ? 3'h0 : phase_ff + 3'h1;
    pulse_ff <= i_pulse_go ? i_pulse_len : pulse_ff - 8'(pulse_ff != 8'h00);
  end

  assign o_ext_clk     = i_clk_run && phase_ff >= 3'h3;
  assign o_capture_pin = pulse_ff != 8'h00;
endmodule // capture_event_source

`default_nettype wire

/* tb/general_capture_timer_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end

module general_capture_timer_test
  import capture_compare_timer_pkg::*;
;
  logic          sys_clk = 1'b0;
  logic          arst_n, enable, cmp_clr, cap_clr, clk_run, pulse_go;
  timer_mode_e   mode;
  clk_src_e      clk_src;
  capture_edge_e cap_edge;
  logic [11:0]   prescale;
  logic [31:0]   compare, count, capture, cap_lead;
  logic [7:0]    pulse_len;
  logic          ext_clk, cap_pin, cmp_flag, cap_flag, cmp_irq;
  int            num_errors = 0, cmp_count = 0, cycles = 0, seed = 32'hca92, p, c, k;

  general_capture_timer i_dut (
    .i_sys_clk      (sys_clk),
    .i_arst_n       (arst_n),
    .i_enable       (enable),
    .i_mode         (mode),
    .i_clk_src      (clk_src),
    .i_capture_edge (cap_edge),
    .i_prescale     (prescale),
    .i_compare      (compare),
    .i_cmp_flag_clr (cmp_clr),
    .i_cap_flag_clr (cap_clr),
    .i_ext_clk      (ext_clk),
    .i_capture_pin  (cap_pin),
    .o_count        (count),
    .o_capture      (capture),
    .o_cmp_flag     (cmp_flag),
    .o_cap_flag     (cap_flag),
    .o_cmp_irq      (cmp_irq)
  );

  capture_event_source i_src (
    .i_sys_clk     (sys_clk),
    .i_clk_run     (clk_run),
    .i_pulse_go    (pulse_go),
    .i_pulse_len   (pulse_len),
    .o_ext_clk     (ext_clk),
    .o_capture_pin (cap_pin)
  );

  function automatic logic [31:0] exp_count(int kk, int pp, int cc, logic per);
    int adv;
    adv = kk / (pp + 1);
    return per ? 32'(adv % (cc + 1)) : 32'(adv);
  endfunction

  task automatic restart(timer_mode_e m, clk_src_e s, capture_edge_e e, int pp, int cc);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    enable <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n   <= 1'b1;
    mode     <= m;
    clk_src  <= s;
    cap_edge <= e;
    prescale <= 12'(pp);
    compare  <= 32'(cc);
    repeat (2) @(posedge sys_clk);
    enable <= 1'b1;
  endtask

  task automatic clear_flags();
    @(posedge sys_clk);
    cmp_clr <= 1'b1;
    cap_clr <= 1'b1;
    @(posedge sys_clk);
    cmp_clr <= 1'b0;
    cap_clr <= 1'b0;
    #1;
  endtask

  task automatic finish_test();
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      finish_test();
    end
  end

  initial
  begin
    {arst_n, enable, cmp_clr, cap_clr, clk_run, pulse_go} = 6'h00;
    mode      = MODE_FREE_RUN;
    clk_src   = CLK_SRC_INTERNAL;
    cap_edge  = EDGE_LEADING;
    prescale  = 12'h000;
    compare   = 32'h0000_0000;
    pulse_len = 8'h00;
    repeat (12) @(posedge sys_clk);
    // Internal clock, random prescale, compare and run length in both modes
    for (int i = 0; i < 40; i++)
    begin
      p = (i == 0) ? 0 : {$random(seed)} % 4;
      c = (i == 0) ? 1 : 1 + {$random(seed)} % 6;
      k = {$random(seed)} % 40;
      restart(timer_mode_e'(i % 2), CLK_SRC_INTERNAL, EDGE_LEADING, p, c);
      repeat (k) @(posedge sys_clk);
      #1;
      `CHECK("count", exp_count(k, p, c, 1'(i % 2)), count)
      `CHECK("cmp_flag", 1'(k / (p + 1) >= c), cmp_flag)
      `CHECK("cmp_irq", 1'(k / (p + 1) >= c), cmp_irq)
    end
    // Periodic flag returns next period with no reload
    restart(MODE_PERIODIC, CLK_SRC_INTERNAL, EDGE_LEADING, 1, 3);
    repeat (6) @(posedge sys_clk);
    clear_flags();
    `CHECK("cmp_clr", 1'b0, cmp_flag)
    repeat (6) @(posedge sys_clk);
    #1;
    `CHECK("period_cnt", 32'h3, count)
    `CHECK("period_irq", 1'b1, cmp_irq)
    // External clock, six rising edges, divided by one and two
    for (int q = 0; q < 2; q++)
    begin
      restart(MODE_FREE_RUN, CLK_SRC_EXTERNAL, EDGE_LEADING, q, 1000);
      clk_run <= 1'b1;
      repeat (37) @(posedge sys_clk);
      clk_run <= 1'b0;
      repeat (12) @(posedge sys_clk);
      #1;
      `CHECK("ext_count", 32'(6 / (q + 1)), count)
    end
    // Same pulse captured on each edge; the values differ by its width
    for (int e = 0; e < 2; e++)
    begin
      restart(MODE_FREE_RUN, CLK_SRC_INTERNAL, capture_edge_e'(e), 0, 1000);
      repeat (5) @(posedge sys_clk);
      pulse_len <= 8'h08;
      pulse_go  <= 1'b1;
      @(posedge sys_clk);
      pulse_go <= 1'b0;
      repeat (20) @(posedge sys_clk);
      #1;
      `CHECK("cap_flag", 1'b1, cap_flag)
      if (e == 0)
        cap_lead = capture;
      else
        `CHECK("cap_diff", 32'h8, capture - cap_lead)
      clear_flags();
      `CHECK("cap_clr", 1'b0, cap_flag)
    end
    finish_test();
  end
endmodule // general_capture_timer_test

`default_nettype wire
